// File: hw/sfx_pkg.sv
// Functional notes
// - decode registers at direct addresses 80..ff
// - only the register range reaches registers
// - standard and mapped areas share range
// - area select bit 1 picks mapped
// - area select bit never cleared by hardware
// - control bit 2 always reads one
// - control bits 7..5,3,1 read zero
// - paged decode adds module page number
// - all modules share one 3-bit page and slot layout
// - four save slots per paged module
// - save write stores old, loads new
// - restore write loads selected slot, ignores page field
// - paging for ports, converter, capture, control
// - operation 0x direct, 10 save, 11 restore
// - page field reads the active page
// - slot selector chooses slot, write-only
package sfx_pkg;
  localparam logic [7:0] SFX_RANGE_LO   = 8'h80;
  localparam logic [7:0] SFX_SYSCON_ADR = 8'h8f;
  localparam logic [7:0] SFX_SYSCON_RST = 8'h04;
  localparam logic [7:0] SFX_SYSCON_ONE = 8'h04;
  localparam int         SFX_AREA_BIT   = 0;
  localparam int         SFX_INT_MODE_BIT = 4;
  localparam logic [7:0] SFX_PP_ADR     = 8'hb2;
  localparam logic [7:0] SFX_ADC_ADR    = 8'hd1;
  localparam logic [7:0] SFX_CCU_ADR    = 8'ha3;
  localparam logic [7:0] SFX_SCU_ADR    = 8'hbf;
  localparam logic [3:0] SFX_PAGED_MAP  = 4'hf;
  localparam int         SFX_NMOD       = 4;
  localparam int         SFX_PAGE_LSB   = 0;
  localparam int         SFX_SLOT_LSB   = 4;
  localparam int         SFX_OPER_LSB   = 6;
  localparam logic [1:0] SFX_OPER_SAVE  = 2'h2;
  localparam logic [1:0] SFX_OPER_REST  = 2'h3;
  localparam logic [2:0] SFX_PAGE_RST   = 3'h0;
  localparam int         SFX_NSLOT      = 4;
  typedef logic [2:0] sfx_page_t;
endpackage : sfx_pkg

// File: hw/sfx_page_reg.sv
`timescale 1ns/1ps
module sfx_page_reg (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             wr,
  input  wire logic [7:0]       wdata,
  output sfx_pkg::sfx_page_t    page
);
  import sfx_pkg::*;
  typedef struct packed {
    sfx_page_t             page;
    sfx_page_t [SFX_NSLOT-1:0] slot;
  } sfx_pg_st_t;
  sfx_pg_st_t st_reg;
  sfx_pg_st_t st_next;
  logic [1:0] oper;
  logic [1:0] sel;
  assign oper = wdata[SFX_OPER_LSB+:2];
  assign sel = wdata[SFX_SLOT_LSB+:2];
  assign page = st_reg.page;
  // ----------------------------------------
  // page operations
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    if (wr) begin
      case (oper)
        SFX_OPER_SAVE: begin
          st_next.slot[sel] = st_reg.page;
          st_next.page      = wdata[SFX_PAGE_LSB+:3];
        end
        SFX_OPER_REST: begin
          st_next.page = st_reg.slot[sel];
        end
        default: begin
          st_next.page = wdata[SFX_PAGE_LSB+:3];
        end
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  a_save_slot: assert property (@(posedge clk) disable iff (rst)
    wr && oper == SFX_OPER_SAVE |=> st_reg.slot[$past(sel)] == $past(st_reg.page))
    else $error("save slot wrong");
  a_rest_page: assert property (@(posedge clk) disable iff (rst)
    wr && oper == SFX_OPER_REST |=> st_reg.page == $past(st_reg.slot[sel]))
    else $error("restore page wrong");
  a_direct_page: assert property (@(posedge clk) disable iff (rst)
    wr && !oper[1] |=> st_reg.page == $past(wdata[SFX_PAGE_LSB+:3]) && $stable(st_reg.slot))
    else $error("direct page wrong");
  a_page_hold: assert property (@(posedge clk) disable iff (rst)
    !wr |=> $stable(st_reg))
    else $error("page changed unasked");
endmodule : sfx_page_reg

// File: hw/sfx_top.sv
`timescale 1ns/1ps
module sfx_top (
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic [7:0]        ADDR,
  input  wire logic              WR,
  input  wire logic              RD,
  input  wire logic [7:0]        WDATA,
  output logic [7:0]             RDATA,
  output logic                   SEL_MAPPED,
  output logic                   SEL_STD,
  output logic                   INT_MODE_OUT,
  output sfx_pkg::sfx_page_t     PAGE_PORTS,
  output sfx_pkg::sfx_page_t     PAGE_ADC,
  output sfx_pkg::sfx_page_t     PAGE_CCU,
  output sfx_pkg::sfx_page_t     PAGE_SCU
);
  import sfx_pkg::*;
  typedef struct packed {
    logic       area;
    logic       int_mode;
    logic [7:0] rdata;
    logic       sel_map;
    logic       sel_std;
  } sfx_st_t;
  sfx_st_t st_reg;
  sfx_st_t st_next;
  logic       in_range;
  logic       hit_sys;
  logic [7:0] sys_read;
  logic [SFX_NMOD-1:0] pg_wr;
  sfx_page_t  pages [SFX_NMOD];
  logic [7:0] mod_adr [SFX_NMOD];
  logic       acc;
  logic       ctrl_wr;
  logic       ctrl_rd;
  logic       any_pg_rd;
  logic [SFX_NMOD-1:0] pg_rd;
  assign mod_adr[0] = SFX_PP_ADR;
  assign mod_adr[1] = SFX_ADC_ADR;
  assign mod_adr[2] = SFX_CCU_ADR;
  assign mod_adr[3] = SFX_SCU_ADR;
  // ----------------------------------------
  // address decode
  // ----------------------------------------
  assign in_range = ADDR >= SFX_RANGE_LO;
  assign hit_sys  = in_range && ADDR == SFX_SYSCON_ADR;
  assign sys_read = SFX_SYSCON_ONE | (8'(st_reg.int_mode) << SFX_INT_MODE_BIT)
                  | (8'(st_reg.area) << SFX_AREA_BIT);
  // ----------------------------------------
  // paged modules
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < SFX_NMOD; g++) begin : g_mod
      // paged registers in mapped area
      assign pg_wr[g] = WR && in_range && ADDR == mod_adr[g]
                      && st_reg.area == SFX_PAGED_MAP[g];
      sfx_page_reg sfx_page_reg_i (
        .clk   (CLK),
        .rst   (RST),
        .wr    (pg_wr[g]),
        .wdata (WDATA),
        .page  (pages[g])
      );
    end
  endgenerate
  // ----------------------------------------
  // state update
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.sel_map = in_range && (RD || WR) && !hit_sys && st_reg.area;
    st_next.sel_std = in_range && (RD || WR) && !hit_sys && !st_reg.area;
    if (WR && hit_sys) begin
      st_next.area  = WDATA[SFX_AREA_BIT];
      st_next.int_mode = WDATA[SFX_INT_MODE_BIT];
    end
    st_next.rdata = 8'h00;
    if (RD && hit_sys) begin
      st_next.rdata = sys_read;
    end else if (RD && in_range) begin
      for (int i = 0; i < SFX_NMOD; i++) begin
        if (ADDR == mod_adr[i] && st_reg.area == SFX_PAGED_MAP[i]) begin
          st_next.rdata = {5'h00, pages[i]};
        end
      end
    end
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign RDATA      = st_reg.rdata;
  assign SEL_MAPPED = st_reg.sel_map;
  assign SEL_STD    = st_reg.sel_std;
  assign INT_MODE_OUT = st_reg.int_mode;
  assign PAGE_PORTS = pages[0];
  assign PAGE_ADC   = pages[1];
  assign PAGE_CCU   = pages[2];
  assign PAGE_SCU   = pages[3];

  // ----------------------------------------
  // check helpers
  // ----------------------------------------
  assign acc       = (RD || WR) && in_range && !hit_sys;
  assign ctrl_wr   = WR && hit_sys;
  assign ctrl_rd   = RD && hit_sys;
  assign any_pg_rd = |pg_rd;

  genvar r;
  generate
    for (r = 0; r < SFX_NMOD; r++) begin : g_rd
      assign pg_rd[r] = RD && in_range && ADDR == mod_adr[r]
                      && st_reg.area == SFX_PAGED_MAP[r];
    end
  endgenerate
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_area_keep: assert property (@(posedge CLK) disable iff (RST)
    !(WR && hit_sys) |=> $stable(st_reg.area))
    else $error("area bit changed without write");
  a_sys_read: assert property (@(posedge CLK) disable iff (RST)
    RD && hit_sys |=> RDATA[2] && RDATA[7:5] == 3'h0 && !RDATA[3] && !RDATA[1])
    else $error("reserved bits wrong");
  a_area_mapped: assert property (@(posedge CLK) disable iff (RST)
    (RD || WR) && in_range && !hit_sys |=> SEL_MAPPED == $past(st_reg.area)
    && SEL_STD != SEL_MAPPED)
    else $error("area select wrong");
  a_out_range: assert property (@(posedge CLK) disable iff (RST)
    !in_range |=> !SEL_MAPPED && !SEL_STD && RDATA == 8'h00)
    else $error("access below range decoded");

  a_sel_excl: assert property (@(posedge CLK) disable iff (RST)
    !(SEL_MAPPED && SEL_STD))
    else $error("both area selects high");

  a_sel_idle: assert property (@(posedge CLK) disable iff (RST)
    !acc
    |=> !SEL_MAPPED && !SEL_STD)
    else $error("area select without access");

  a_map_pulse: assert property (@(posedge CLK) disable iff (RST)
    acc && st_reg.area
    |=> SEL_MAPPED)
    else $error("mapped select missing");

  a_std_pulse: assert property (@(posedge CLK) disable iff (RST)
    acc && !st_reg.area
    |=> SEL_STD)
    else $error("standard select missing");

  a_sel_from_rd: assert property (@(posedge CLK) disable iff (RST)
    RD && in_range && !hit_sys
    |=> SEL_MAPPED || SEL_STD)
    else $error("read select missing");

  a_sel_from_wr: assert property (@(posedge CLK) disable iff (RST)
    WR && in_range && !hit_sys
    |=> SEL_MAPPED || SEL_STD)
    else $error("write select missing");

  a_rdata_idle: assert property (@(posedge CLK) disable iff (RST)
    !RD
    |=> RDATA == 8'h00)
    else $error("read data without read");

  a_rdata_unmapped: assert property (@(posedge CLK) disable iff (RST)
    RD && in_range && !hit_sys && !any_pg_rd
    |=> RDATA == 8'h00)
    else $error("read data from empty address");

  a_area_write: assert property (@(posedge CLK) disable iff (RST)
    ctrl_wr
    |=> st_reg.area == $past(WDATA[SFX_AREA_BIT]))
    else $error("area bit write lost");

  a_area_rise: assert property (@(posedge CLK) disable iff (RST)
    $rose(st_reg.area)
    |-> $past(ctrl_wr))
    else $error("area bit set unasked");

  a_area_fall: assert property (@(posedge CLK) disable iff (RST)
    $fell(st_reg.area)
    |-> $past(ctrl_wr))
    else $error("area bit cleared unasked");

  a_mode_write: assert property (@(posedge CLK) disable iff (RST)
    ctrl_wr
    |=> INT_MODE_OUT == $past(WDATA[SFX_INT_MODE_BIT]))
    else $error("mode bit write lost");

  a_mode_keep: assert property (@(posedge CLK) disable iff (RST)
    !ctrl_wr
    |=> $stable(INT_MODE_OUT))
    else $error("mode bit changed unasked");

  a_mode_rise: assert property (@(posedge CLK) disable iff (RST)
    $rose(INT_MODE_OUT)
    |-> $past(ctrl_wr))
    else $error("mode bit set unasked");

  a_mode_fall: assert property (@(posedge CLK) disable iff (RST)
    $fell(INT_MODE_OUT)
    |-> $past(ctrl_wr))
    else $error("mode bit cleared unasked");

  a_ctrl_area_rd: assert property (@(posedge CLK) disable iff (RST)
    ctrl_rd
    |=> RDATA[SFX_AREA_BIT] == $past(st_reg.area))
    else $error("area bit read wrong");

  a_ctrl_mode_rd: assert property (@(posedge CLK) disable iff (RST)
    ctrl_rd
    |=> RDATA[SFX_INT_MODE_BIT] == $past(st_reg.int_mode))
    else $error("mode bit read wrong");

  a_ctrl_rd_fixed: assert property (@(posedge CLK) disable iff (RST)
    ctrl_rd
    |=> (RDATA & 8'hee) == SFX_SYSCON_ONE)
    else $error("fixed control bits wrong");

  a_ctrl_no_sel: assert property (@(posedge CLK) disable iff (RST)
    ctrl_rd || ctrl_wr
    |=> !SEL_MAPPED && !SEL_STD)
    else $error("control access selected an area");

  a_page_rd_high: assert property (@(posedge CLK) disable iff (RST)
    any_pg_rd
    |=> RDATA < 8'h08)
    else $error("write-only page bits read back");

  a_low_pages: assert property (@(posedge CLK) disable iff (RST)
    !in_range
    |=> $stable(PAGE_PORTS) && $stable(PAGE_ADC) && $stable(PAGE_CCU) && $stable(PAGE_SCU))
    else $error("page changed from low address");

  // ----------------------------------------
  // per-module page checks
  // ----------------------------------------
  genvar h;
  generate
    for (h = 0; h < SFX_NMOD; h++) begin : g_chk

      a_mod_idle: assert property (@(posedge CLK) disable iff (RST)
        !pg_wr[h]
        |=> $stable(pages[h]))
        else $error("module page changed unasked");

      a_mod_area: assert property (@(posedge CLK) disable iff (RST)
        WR && in_range && ADDR == mod_adr[h] && st_reg.area != SFX_PAGED_MAP[h]
        |=> $stable(pages[h]))
        else $error("page written in wrong area");

      a_mod_ctrl: assert property (@(posedge CLK) disable iff (RST)
        ctrl_wr
        |=> $stable(pages[h]))
        else $error("page changed by control write");

      a_mod_read: assert property (@(posedge CLK) disable iff (RST)
        pg_rd[h]
        |=> RDATA == {5'h00, $past(pages[h])})
        else $error("module page read wrong");

      a_mod_direct: assert property (@(posedge CLK) disable iff (RST)
        pg_wr[h] && !WDATA[SFX_OPER_LSB+1]
        |=> pages[h] == $past(WDATA[SFX_PAGE_LSB+:3]))
        else $error("module direct page wrong");

      a_mod_save: assert property (@(posedge CLK) disable iff (RST)
        pg_wr[h] && WDATA[SFX_OPER_LSB+:2] == SFX_OPER_SAVE
        |=> pages[h] == $past(WDATA[SFX_PAGE_LSB+:3]))
        else $error("module save page wrong");

      a_mod_sel: assert property (@(posedge CLK) disable iff (RST)
        pg_wr[h] || pg_rd[h]
        |=> SEL_MAPPED == SFX_PAGED_MAP[h])
        else $error("module access in wrong area");

    end
  endgenerate

endmodule : sfx_top

// File: bench/sfx_cpu_model.sv
`timescale 1ns/1ps
module sfx_cpu_model (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output logic [7:0]      addr,
  output logic            wr,
  output logic            rd,
  output logic [7:0]      wdata
);
  initial begin
    addr = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
  // read-modify-write of the area bit before each area change
  task automatic set_area(input logic b);
    logic [7:0] v;
    rd_reg(8'h8f, v);
    if (b) begin
      wr_reg(8'h8f, v | 8'h01);
    end else begin
      wr_reg(8'h8f, v & 8'hfe);
    end
  endtask : set_area
endmodule : sfx_cpu_model

// File: bench/sfr_address_extension_tb.sv
`timescale 1ns/1ps
module sfr_address_extension_tb;
  import sfx_pkg::*;
  localparam logic [7:0] page_adr [4] = '{SFX_PP_ADR, SFX_ADC_ADR, SFX_CCU_ADR, SFX_SCU_ADR};
  logic clk, rst, wr, rd, sel_m, sel_s, int_mode;
  logic [7:0] addr, wdata, rdata, v;
  sfx_page_t pg [4];
  int err_total, samples_checked;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  sfx_cpu_model sfx_cpu_model_i (.clk(clk), .rdata(rdata), .addr(addr), .wr(wr), .rd(rd),
    .wdata(wdata));
  sfx_top sfx_top_i (.CLK(clk), .RST(rst), .ADDR(addr), .WR(wr), .RD(rd), .WDATA(wdata),
    .RDATA(rdata), .SEL_MAPPED(sel_m), .SEL_STD(sel_s), .INT_MODE_OUT(int_mode),
    .PAGE_PORTS(pg[0]), .PAGE_ADC(pg[1]), .PAGE_CCU(pg[2]), .PAGE_SCU(pg[3]));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #1ms;
    err_total++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    sfx_cpu_model_i.rd_reg(8'h8f, v);
    chk("ctrl reset", SFX_SYSCON_RST, v);
    sfx_cpu_model_i.wr_reg(8'h8f, 8'hfe);
    sfx_cpu_model_i.rd_reg(8'h8f, v);
    chk("ctrl fields", 8'h14, v);
    chk("int mode", 8'h01, {7'h0, int_mode});
    sfx_cpu_model_i.wr_reg(8'h0f, 8'h01);
    sfx_cpu_model_i.wr_reg(SFX_PP_ADR, 8'h03);
    sfx_cpu_model_i.rd_reg(SFX_PP_ADR, v);
    chk("std sel", 8'h01, {7'h0, sel_s});
    chk("std page", 8'h00, {5'h0, pg[0]});
    sfx_cpu_model_i.rd_reg(8'h8f, v);
    chk("low addr", 8'h14, v);
    sfx_cpu_model_i.set_area(1'b1);
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 4; s++) begin
        sfx_cpu_model_i.wr_reg(page_adr[m], {2'b01, 2'(3 - s), 1'b0, 3'(s)});
        sfx_cpu_model_i.wr_reg(page_adr[m], {2'b10, 2'(s), 1'b0, 3'(s + 4)});
        #1;
        chk("save page", {5'h0, 3'(s + 4)}, {5'h0, pg[m]});
      end
      for (int s = 0; s < 4; s++) begin
        sfx_cpu_model_i.wr_reg(page_adr[m], {2'b11, 2'(s), 4'h7});
        #1;
        chk("restore", {5'h0, 3'(s)}, {5'h0, pg[m]});
      end
      sfx_cpu_model_i.rd_reg(page_adr[m], v);
      chk("page read", 8'h03, v);
      chk("map sel", 8'h01, {7'h0, sel_m});
    end
    sfx_cpu_model_i.rd_reg(8'h8f, v);
    chk("area kept", 8'h15, v);
    sfx_cpu_model_i.set_area(1'b0);
    sfx_cpu_model_i.rd_reg(8'h8f, v);
    chk("area off", 8'h14, v);
    report_and_stop();
  end
endmodule : sfr_address_extension_tb
